// ### rtl/adcsm_pkg.sv
// Shared constants, register map and types for the setup and conversion mode block
// Notes on behaviour
// - Eight setup slots, each holding config, filter, offset and gain; channel picks one.
// - Slot config drives amp gain, bypass, reference, buffers, burnout and excitation choices.
// - Slot filter selects filter type and an eleven-bit filter rate value.
// - Slot repeat field gives one to thirty-two conversions per channel visit.
// - Slot settling field sets a front-end delay before conversion starts.
// - Calibration results are written into offset or gain of the active slot.
// - Mode field selects continuous (reset), single sequence or duty cycling.
// - Two more codes select single sequence restarted by sync from idle or standby.
// - Continuous mode loops over enabled channels, wrapping to the lowest one.
// - Single sequence mode visits enabled channels once, then enters standby.
// - Register writes are dropped while a single sequence is converting.
// - Idle-by-sync holds modulator and filter in reset; sync pulse starts a sequence.
// - Standby-by-sync leaves standby on a sync pulse; registers are kept.
// - Repeat counts apply in standby-by-sync mode.
// - Duty cycling converts all enabled channels, stands by, then repeats autonomously.
// - Duty active share is one quarter, or one sixteenth when ratio bit set.
// - Duty cycling ignores repeat counts: one conversion per channel per cycle.
// - Channels are visited in increasing index order, lowest enabled first.
// - Each channel selection waits its slot settling time before converting.
package adcsm_pkg;

	localparam int NUM_SLOTS = 8;
	localparam int NUM_CH    = 16;

	// Printed offsets are word indices; byte address is four times these
	localparam logic [5:0] IDX_STATUS   = 6'h00;
	localparam logic [5:0] IDX_CONTROL  = 6'h01;
	localparam logic [5:0] IDX_CH_BASE  = 6'h09;
	localparam logic [5:0] IDX_CFG_BASE = 6'h19;
	localparam logic [5:0] IDX_FLT_BASE = 6'h21;
	localparam logic [5:0] IDX_OFS_BASE = 6'h29;
	localparam logic [5:0] IDX_GN_BASE  = 6'h31;
	localparam logic [5:0] IDX_MISC     = 6'h39;

	localparam logic [15:0] CONTROL_RST = 16'h4000;
	localparam logic [23:0] CH0_RST     = 24'h80_0100;
	localparam logic [23:0] CH_RST      = 24'h00_0100;
	localparam logic [15:0] CFG_RST     = 16'h0000;
	localparam logic [23:0] FLT_RST     = 24'h00_2030;
	localparam logic [15:0] OFS_RST     = 16'h8000;
	localparam logic [15:0] GAIN_RST    = 16'h8000;
	localparam logic [7:0]  MISC_RST    = 8'h00;

	localparam int CTL_MODE_LSB    = 2;
	localparam int CTL_DUTY_BIT    = 6;
	localparam int CH_EN_BIT       = 23;
	localparam int CH_SETUP_LSB    = 20;
	localparam int FLT_SETTLE_LSB  = 21;
	localparam int FLT_REPEAT_LSB  = 16;
	localparam int FLT_MODE_LSB    = 12;
	localparam int FLT_FS_LSB      = 0;
	localparam int MISC_REFHOLD    = 0;
	localparam int STAT_STANDBY_STATE_BIT   = 4;
	localparam int STAT_BUSY_BIT   = 5;

	localparam int DUTY_SHIFT_QUARTER   = 2;
	localparam int DUTY_SHIFT_SIXTEENTH = 4;

	typedef enum logic [3:0] {
		MODE_CONT      = 4'h0,
		MODE_SINGLE    = 4'h1,
		MODE_DUTY      = 4'h9,
		MODE_SYNC_IDLE = 4'hA,
		MODE_SYNC_STANDBY_STATE = 4'hB
	} adcsm_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETTLE = 3'h1,
		ST_CONV   = 3'h3,
		ST_STANDBY_STATE   = 3'h2,
		ST_PDOWN  = 3'h6
	} adcsm_state_t;

endpackage

// ### rtl/adcsm_timer.sv
// Down counter that times settling, conversion and standby spans
`timescale 1ns/10ps
`default_nettype none
module adcsm_timer #(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Load and expiry
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_val,
	output logic                  expired
);

	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= (load_val == '0) ? CNT_W'(1) : load_val;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - CNT_W'(1);
	end

	// Last counted cycle; a zero count never fires
	// Independent of load, which is itself derived from expiry
	assign expired = (cnt_q == CNT_W'(1));

endmodule // adcsm_timer
`default_nettype wire

// ### rtl/adcsm_top.sv
// APB register file and channel sequencer for the conversion modes
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module adcsm_top
	import adcsm_pkg::*;
#(
	parameter int CNT_W       = 24,
	parameter int CONV_UNIT   = 16,
	parameter int SETTLE_UNIT = 64
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata_q,
	output logic             pready_q,
	output logic             pslverr_q,
	// Sync pin, active low pulse
	input  wire logic        sync_n,
	// Calibration results
	input  wire logic        cal_valid,
	input  wire logic        cal_sel_gain,
	input  wire logic [15:0] cal_value,
	// Front end control
	output logic             conv_done_q,
	output logic [3:0]       active_ch_q,
	output logic             mod_reset_q,
	output logic             standby_state_q,
	output logic             ref_hold_q,
	output logic [15:0]      fe_config_q,
	output logic [3:0]       filter_type_q,
	output logic [10:0]      filter_rate_value_q
);

	logic [15:0]      control_q;
	logic [7:0]       misc_q;
	logic [23:0]      chan_q [NUM_CH];
	logic [15:0]      cfg_q  [NUM_SLOTS];
	logic [23:0]      flt_q  [NUM_SLOTS];
	logic [15:0]      ofs_q  [NUM_SLOTS];
	logic [15:0]      gain_q [NUM_SLOTS];
	logic [NUM_CH-1:0] en_vec;

	adcsm_state_t     state_q, state_d;
	logic [3:0]       cur_ch_q, ch_d;
	logic [4:0]       rep_q, rep_d;
	logic [CNT_W-1:0] act_q;
	logic [CNT_W-1:0] act_len;
	logic             sync_prev_q;
	logic             t_load, expired, go;
	logic [CNT_W-1:0] t_val;

	adcsm_mode_t      mode;
	logic [5:0]       idx;
	logic             setup_ph, access_wr, seq_busy, single_fam, ignore_wr, wr_ok, ctl_wr;
	logic             ch_hit, cfg_hit, flt_hit, ofs_hit, gn_hit;
	logic [3:0]       ch_idx;
	logic [2:0]       slot_idx, slot_cur, slot_nxt;
	logic [31:0]      rd_data;
	logic             rd_err;
	logic [4:0]       first, nxt;
	logic             sync_rise;

	assign mode      = adcsm_mode_t'(control_q[CTL_MODE_LSB +: 4]);
	assign idx       = paddr[7:2];
	assign setup_ph  = psel && !penable;
	assign access_wr = psel && penable && pready_q && pwrite;
	assign sync_rise = sync_n && !sync_prev_q;

	assign ch_hit  = (idx >= IDX_CH_BASE) && (idx < IDX_CFG_BASE);
	assign cfg_hit = (idx >= IDX_CFG_BASE) && (idx < IDX_FLT_BASE);
	assign flt_hit = (idx >= IDX_FLT_BASE) && (idx < IDX_OFS_BASE);
	assign ofs_hit = (idx >= IDX_OFS_BASE) && (idx < IDX_GN_BASE);
	assign gn_hit  = (idx >= IDX_GN_BASE) && (idx < IDX_MISC);
	assign ch_idx  = 4'(idx - IDX_CH_BASE);
	assign slot_idx = cfg_hit ? 3'(idx - IDX_CFG_BASE) :
	                  flt_hit ? 3'(idx - IDX_FLT_BASE) :
	                  ofs_hit ? 3'(idx - IDX_OFS_BASE) : 3'(idx - IDX_GN_BASE);

	assign seq_busy   = (state_q == ST_SETTLE) || (state_q == ST_CONV);
	assign single_fam = (mode == MODE_SINGLE) || (mode == MODE_SYNC_IDLE) || (mode == MODE_SYNC_STANDBY_STATE);
	assign ignore_wr  = seq_busy && single_fam;
	assign wr_ok      = access_wr && !ignore_wr;
	assign ctl_wr     = wr_ok && (idx == IDX_CONTROL);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_q <= CONTROL_RST;
			misc_q    <= MISC_RST;
		end
		else
		begin
			if (ctl_wr)
				control_q <= pwdata[15:0];
			if (wr_ok && idx == IDX_MISC)
				misc_q <= pwdata[7:0];
		end
	end

	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				chan_q[g] <= (g == 0) ? CH0_RST : CH_RST;
			else if (wr_ok && ch_hit && ch_idx == 4'(g))
				chan_q[g] <= pwdata[23:0];
		end
		assign en_vec[g] = chan_q[g][CH_EN_BIT];
	end

	// Calibration wins over a bus write to the same word
	for (genvar s = 0; s < NUM_SLOTS; s++)
	begin : g_slot
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cfg_q[s]  <= CFG_RST;
				flt_q[s]  <= FLT_RST;
				ofs_q[s]  <= OFS_RST;
				gain_q[s] <= GAIN_RST;
			end
			else
			begin
				if (wr_ok && cfg_hit && slot_idx == 3'(s))
					cfg_q[s] <= pwdata[15:0];
				if (wr_ok && flt_hit && slot_idx == 3'(s))
					flt_q[s] <= pwdata[23:0];
				if (cal_valid && !cal_sel_gain && slot_cur == 3'(s))
					ofs_q[s] <= cal_value;
				else if (wr_ok && ofs_hit && slot_idx == 3'(s))
					ofs_q[s] <= pwdata[15:0];
				if (cal_valid && cal_sel_gain && slot_cur == 3'(s))
					gain_q[s] <= cal_value;
				else if (wr_ok && gn_hit && slot_idx == 3'(s))
					gain_q[s] <= pwdata[15:0];
			end
		end
	end

	always_comb
	begin
		rd_data = '0;
		rd_err  = 1'b0;
		if (idx == IDX_STATUS)
			rd_data = {26'h000_0000, seq_busy, state_q == ST_STANDBY_STATE, cur_ch_q};
		else if (idx == IDX_CONTROL)
			rd_data = {16'h0000, control_q};
		else if (idx == IDX_MISC)
			rd_data = {24'h00_0000, misc_q};
		else if (ch_hit)
			rd_data = {8'h00, chan_q[ch_idx]};
		else if (cfg_hit)
			rd_data = {16'h0000, cfg_q[slot_idx]};
		else if (flt_hit)
			rd_data = {8'h00, flt_q[slot_idx]};
		else if (ofs_hit)
			rd_data = {16'h0000, ofs_q[slot_idx]};
		else if (gn_hit)
			rd_data = {16'h0000, gain_q[slot_idx]};
		else
			rd_err = 1'b1;
	end

	// One wait-free access phase; data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end
		else
		begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph && rd_err;
			if (setup_ph && !pwrite)
				prdata_q <= rd_data;
		end
	end

	// Lowest enabled channel at or above from; bit 4 set when none
	function automatic logic [4:0] next_en(input logic [NUM_CH-1:0] en, input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (en[i] && 5'(i) >= from)
				r = {1'b0, 4'(i)};
		return r;
	endfunction

	function automatic logic [CNT_W-1:0] settle_len(input logic [23:0] f);
		return CNT_W'((int'(f[FLT_SETTLE_LSB +: 3]) + 1) * SETTLE_UNIT);
	endfunction

	function automatic logic [CNT_W-1:0] conv_len(input logic [23:0] f);
		return CNT_W'((int'(f[FLT_FS_LSB +: 11]) + 1) * CONV_UNIT);
	endfunction

	assign first    = next_en(en_vec, 5'h00);
	assign nxt      = next_en(en_vec, {1'b0, cur_ch_q} + 5'h01);
	assign slot_cur = chan_q[cur_ch_q][CH_SETUP_LSB +: 3];
	assign slot_nxt = chan_q[ch_d][CH_SETUP_LSB +: 3];

	adcsm_timer #(
		.CNT_W    (CNT_W)
	) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (t_load),
		.load_val (t_val),
		.expired  (expired)
	);

	always_comb
	begin
		state_d = state_q;
		ch_d    = cur_ch_q;
		rep_d   = rep_q;
		t_load  = 1'b0;
		t_val   = '0;
		go      = 1'b0;
		if (ctl_wr)
			state_d = ST_IDLE;
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					unique case (mode)
						MODE_CONT, MODE_SINGLE, MODE_DUTY: go = 1'b1;
						MODE_SYNC_IDLE, MODE_SYNC_STANDBY_STATE: go = sync_rise;
						default: state_d = ST_PDOWN;
					endcase
				end
				ST_SETTLE:
				begin
					if (expired)
					begin
						state_d = ST_CONV;
						t_load  = 1'b1;
						t_val   = conv_len(flt_q[slot_cur]);
						// Duty cycling makes one conversion per channel
						rep_d = (mode == MODE_DUTY) ? 5'h00 : flt_q[slot_cur][FLT_REPEAT_LSB +: 5];
					end
				end
				ST_CONV:
				begin
					if (expired)
					begin
						if (rep_q != 5'h00)
						begin
							rep_d  = rep_q - 5'h01;
							t_load = 1'b1;
							t_val  = conv_len(flt_q[slot_cur]);
						end
						else if (!nxt[4])
						begin
							ch_d    = nxt[3:0];
							state_d = ST_SETTLE;
							t_load  = 1'b1;
							t_val   = settle_len(flt_q[chan_q[nxt[3:0]][CH_SETUP_LSB +: 3]]);
						end
						else
						begin
							unique case (mode)
								MODE_CONT: go = 1'b1;
								MODE_SINGLE, MODE_SYNC_STANDBY_STATE: state_d = ST_STANDBY_STATE;
								MODE_SYNC_IDLE: state_d = ST_IDLE;
								MODE_DUTY:
								begin
									state_d = ST_STANDBY_STATE;
									t_load  = 1'b1;
									// Standby lasts three or fifteen times the active span
									t_val = control_q[CTL_DUTY_BIT] ?
										(act_len << DUTY_SHIFT_SIXTEENTH) - act_len :
										(act_len << DUTY_SHIFT_QUARTER) - act_len;
								end
								default: state_d = ST_IDLE;
							endcase
						end
					end
				end
				ST_STANDBY_STATE:
				begin
					// Registers are untouched while standing by
					if (mode == MODE_SYNC_STANDBY_STATE)
						go = sync_rise;
					else if (mode == MODE_DUTY)
						go = expired;
				end
				ST_PDOWN: state_d = ST_PDOWN;
			endcase
			if (go)
			begin
				if (first[4])
					state_d = ST_IDLE;
				else
				begin
					ch_d    = first[3:0];
					state_d = ST_SETTLE;
					t_load  = 1'b1;
					t_val   = settle_len(flt_q[chan_q[first[3:0]][CH_SETUP_LSB +: 3]]);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q     <= ST_IDLE;
			cur_ch_q    <= 4'h0;
			rep_q       <= 5'h00;
			sync_prev_q <= 1'b1;
		end
		else
		begin
			state_q     <= state_d;
			cur_ch_q    <= ch_d;
			rep_q       <= rep_d;
			sync_prev_q <= sync_n;
		end
	end

	// Counter lags by the closing busy cycle
	assign act_len = act_q + CNT_W'(1);

	// Active span of the current duty cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			act_q <= '0;
		else if (go || ctl_wr)
			act_q <= '0;
		else if (seq_busy)
			act_q <= act_q + CNT_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_done_q         <= 1'b0;
			active_ch_q         <= 4'h0;
			mod_reset_q         <= 1'b1;
			standby_state_q     <= 1'b0;
			ref_hold_q          <= 1'b0;
			fe_config_q         <= CFG_RST;
			filter_type_q       <= FLT_RST[FLT_MODE_LSB +: 4];
			filter_rate_value_q <= FLT_RST[FLT_FS_LSB +: 11];
		end
		else
		begin
			conv_done_q         <= (state_q == ST_CONV) && expired && !ctl_wr;
			active_ch_q         <= ch_d;
			mod_reset_q         <= (state_d == ST_IDLE) || (state_d == ST_PDOWN);
			standby_state_q     <= state_d == ST_STANDBY_STATE;
			ref_hold_q          <= (state_d == ST_STANDBY_STATE) && misc_q[MISC_REFHOLD];
			fe_config_q         <= cfg_q[slot_nxt];
			filter_type_q       <= flt_q[slot_nxt][FLT_MODE_LSB +: 4];
			filter_rate_value_q <= flt_q[slot_nxt][FLT_FS_LSB +: 11];
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_single_to_standby_state: assert property (
		state_q == ST_CONV && expired && mode == MODE_SINGLE && rep_q == 5'h00 && nxt[4] && !ctl_wr
		|=> state_q == ST_STANDBY_STATE && standby_state_q)
		else $error("single sequence did not stand by");

	chk_write_dropped: assert property (
		access_wr && idx == IDX_CONTROL && seq_busy && single_fam |=> $stable(control_q))
		else $error("write taken during single sequence");

	chk_idle_hold: assert property (
		state_q == ST_IDLE && mode == MODE_SYNC_IDLE && !sync_rise && !ctl_wr
		|=> state_q == ST_IDLE && mod_reset_q)
		else $error("idle left without sync");

	chk_sync_wake: assert property (
		state_q == ST_STANDBY_STATE && mode == MODE_SYNC_STANDBY_STATE && sync_rise && !first[4] && !ctl_wr
		|=> state_q == ST_SETTLE && cur_ch_q == $past(first[3:0]))
		else $error("sync did not start sequence");

	chk_duty_single: assert property (
		state_q == ST_SETTLE && expired && mode == MODE_DUTY && !ctl_wr |=> rep_q == 5'h00)
		else $error("repeat used in duty cycling");

	chk_pdown_stay: assert property (
		state_q == ST_PDOWN && !ctl_wr |=> state_q == ST_PDOWN && mod_reset_q && !conv_done_q)
		else $error("power-down started conversion");

	chk_chan_order: assert property (
		state_q == ST_CONV && expired && rep_q == 5'h00 && !nxt[4] && !ctl_wr
		|=> state_q == ST_SETTLE && cur_ch_q > $past(cur_ch_q))
		else $error("channel order not increasing");

	chk_settle_first: assert property (
		state_q == ST_CONV && $past(state_q) != ST_CONV |-> $past(state_q) == ST_SETTLE)
		else $error("conversion began without settling");

	chk_cont_wrap: assert property (
		state_q == ST_CONV && expired && mode == MODE_CONT && rep_q == 5'h00 && nxt[4] && !first[4] && !ctl_wr
		|=> state_q == ST_SETTLE && cur_ch_q == $past(first[3:0]))
		else $error("continuous mode did not wrap");

	chk_cal_offset: assert property (
		cal_valid && !cal_sel_gain |=> ofs_q[$past(slot_cur)] == $past(cal_value))
		else $error("calibration offset not stored");

endmodule // adcsm_top
`default_nettype wire

// ### tb/adcsm_host_model.sv
// Host-side model driving the sync pin and calibration results
`timescale 1ns/10ps
`default_nettype none
module adcsm_host_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Requests from the bench
	input  wire logic        sync_go,
	input  wire logic        cal_go,
	input  wire logic        cal_gain_in,
	input  wire logic [15:0] cal_val_in,
	// Pins towards the block
	output logic             sync_n,
	output logic             cal_valid,
	output logic             cal_sel_gain,
	output logic [15:0]      cal_value
);
	logic [2:0] low_cnt;
	// Four-cycle low pulse; the bench only asks once the block is idle or standing by
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_cnt <= 3'h0;
			sync_n  <= 1'b1;
		end
		else if (sync_go)
		begin
			low_cnt <= 3'h4;
			sync_n  <= 1'b0;
		end
		else if (low_cnt != 3'h0)
		begin
			low_cnt <= low_cnt - 3'h1;
			sync_n  <= (low_cnt == 3'h1);
		end
	end
	// Qualifiers toggle outside the valid cycle so stale data cannot pass
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_valid    <= 1'b0;
			cal_sel_gain <= 1'b0;
			cal_value    <= 16'h0000;
		end
		else
		begin
			cal_valid    <= cal_go;
			cal_sel_gain <= cal_go ? cal_gain_in : ~cal_sel_gain;
			cal_value    <= cal_go ? cal_val_in : ~cal_value;
		end
	end
endmodule // adcsm_host_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the setup and conversion mode block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import adcsm_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, sync_go, cal_go, cal_gain, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rdata, prdata_q;
	logic        pready_q, pslverr_q, sync_n, cal_valid, cal_sel_gain;
	logic        conv_done_q, mod_reset_q, standby_state_q, ref_hold_q;
	logic [15:0] cal_val, cal_value, fe_config_q, cv;
	logic [3:0]  active_ch_q, filter_type_q;
	logic [10:0] filter_rate_value_q;
	logic [19:0] q[$];
	logic [19:0] prev;
	logic [15:0] cfg_exp[8];
	int          n_errors, checked, act, st;
	logic [5:0]  ri[8] = '{IDX_CONTROL, IDX_CH_BASE, 6'h0A, IDX_CFG_BASE, IDX_FLT_BASE, IDX_OFS_BASE,
		IDX_GN_BASE, IDX_MISC};
	logic [31:0] rv[8] = '{32'(CONTROL_RST), 32'(CH0_RST), 32'(CH_RST), 32'(CFG_RST), 32'(FLT_RST),
		32'(OFS_RST), 32'(GAIN_RST), 32'(MISC_RST)};
	logic [3:0]  ech[4] = '{4'h2, 4'h5, 4'h5, 4'h5};
	logic [3:0]  pdm[4] = '{4'h2, 4'h3, 4'h8, 4'hF};

	adcsm_top #(.CNT_W(24), .CONV_UNIT(1), .SETTLE_UNIT(1)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .sync_n(sync_n),
		.cal_valid(cal_valid), .cal_sel_gain(cal_sel_gain), .cal_value(cal_value),
		.conv_done_q(conv_done_q), .active_ch_q(active_ch_q), .mod_reset_q(mod_reset_q),
		.standby_state_q(standby_state_q), .ref_hold_q(ref_hold_q), .fe_config_q(fe_config_q),
		.filter_type_q(filter_type_q), .filter_rate_value_q(filter_rate_value_q));
	adcsm_host_model i_host (.pclk(pclk), .presetn(presetn), .sync_go(sync_go), .cal_go(cal_go),
		.cal_gain_in(cal_gain), .cal_val_in(cal_val), .sync_n(sync_n), .cal_valid(cal_valid),
		.cal_sel_gain(cal_sel_gain), .cal_value(cal_value));

	always #12.5 pclk = ~pclk;
	// Channel and config of the last converting cycle, logged per finished conversion
	always @(posedge pclk)
	begin
		if (conv_done_q === 1'b1)
			q.push_back(prev);
		prev <= {fe_config_q, active_ch_q};
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {i, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_q !== 1'b1);
		rdata = prdata_q;
		rerr = pslverr_q;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mode(input logic [3:0] m, input logic r);
		apb(1'b1, IDX_CONTROL, 32'(CONTROL_RST) | (32'(m) << CTL_MODE_LSB) | (32'(r) << CTL_DUTY_BIT));
		repeat (3) @(posedge pclk);
		q.delete();
	endtask
	task automatic wstb(input logic v);
		do @(posedge pclk); while (standby_state_q !== v);
	endtask
	task automatic pulse_sync();
		sync_go <= 1'b1;
		@(posedge pclk);
		sync_go <= 1'b0;
	endtask
	task automatic cal(input logic g, input logic [15:0] v);
		cal_val  <= v;
		cal_gain <= g;
		cal_go   <= 1'b1;
		@(posedge pclk);
		cal_go   <= 1'b0;
	endtask
	task automatic tally_and_finish();
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, sync_go, cal_go, cal_gain} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		cal_val = 16'h0000;
		n_errors = 0;
		checked = 0;
		void'($urandom(32'h451c1c6b));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ri[k])
		begin
			apb(1'b0, ri[k], 32'h0000_0000);
			chk(rdata, rv[k]);
			chk(rerr, 32'h0000_0000);
		end
		apb(1'b0, 6'h3A, 32'h0000_0000);
		chk(rerr, 32'h0000_0001);
		// Random slot configs, kept for later comparison against the front-end outputs
		foreach (cfg_exp[k])
		begin
			cfg_exp[k] = 16'($urandom);
			apb(1'b1, IDX_CFG_BASE + 6'(k), 32'(cfg_exp[k]));
			apb(1'b0, IDX_CFG_BASE + 6'(k), 32'h0000_0000);
			chk(rdata, 32'(cfg_exp[k]));
		end
		apb(1'b1, IDX_CH_BASE, 32'h0000_0000);
		apb(1'b1, IDX_CH_BASE + 6'h02, 32'h0090_0000);
		apb(1'b1, IDX_CH_BASE + 6'h05, 32'h0080_0000);
		apb(1'b1, IDX_FLT_BASE, 32'(FLT_RST) | (32'h2 << FLT_REPEAT_LSB));
		mode(MODE_CONT, 1'b0);
		while (q.size() < 5) @(posedge pclk);
		foreach (ech[k])
		begin
			chk(q[k][3:0], ech[k]);
			chk(q[k][19:4], cfg_exp[ech[k] == 4'h2]);
		end
		chk(q[4][3:0], 4'h2);
		while (active_ch_q !== 4'h2) @(posedge pclk);
		chk(filter_type_q, 32'(FLT_RST[FLT_MODE_LSB +: 4]));
		chk(filter_rate_value_q, 32'(FLT_RST[FLT_FS_LSB +: 11]));
		cv = 16'($urandom);
		cal(1'b1, cv);
		repeat (3) @(posedge pclk);
		apb(1'b0, IDX_GN_BASE + 6'h01, 32'h0000_0000);
		chk(rdata, 32'(cv));
		apb(1'b0, IDX_OFS_BASE + 6'h01, 32'h0000_0000);
		chk(rdata, 32'(OFS_RST));
		cv = ~cv;
		cal(1'b0, cv);
		repeat (3) @(posedge pclk);
		apb(1'b0, IDX_OFS_BASE + 6'h01, 32'h0000_0000);
		chk(rdata, 32'(cv));
		mode(MODE_SINGLE, 1'b0);
		apb(1'b1, IDX_CFG_BASE, 32'(~cfg_exp[0]));
		apb(1'b1, IDX_CONTROL, 32'(CONTROL_RST));
		wstb(1'b1);
		repeat (2) @(posedge pclk);
		chk(q.size(), 4);
		apb(1'b0, IDX_CFG_BASE, 32'h0000_0000);
		chk(rdata, 32'(cfg_exp[0]));
		apb(1'b0, IDX_CONTROL, 32'h0000_0000);
		chk(rdata, 32'(CONTROL_RST) | (32'(MODE_SINGLE) << CTL_MODE_LSB));
		cfg_exp[0] = ~cfg_exp[0];
		apb(1'b1, IDX_CFG_BASE, 32'(cfg_exp[0]));
		apb(1'b0, IDX_CFG_BASE, 32'h0000_0000);
		chk(rdata, 32'(cfg_exp[0]));
		mode(MODE_SYNC_STANDBY_STATE, 1'b0);
		// Mode change leaves the block idle; a first pulse brings it to standby
		pulse_sync();
		wstb(1'b1);
		repeat (2) @(posedge pclk);
		q.delete();
		pulse_sync();
		wstb(1'b0);
		wstb(1'b1);
		repeat (2) @(posedge pclk);
		chk(q.size(), 4);
		apb(1'b0, IDX_CH_BASE + 6'h02, 32'h0000_0000);
		chk(rdata, 32'h0090_0000);
		mode(MODE_SYNC_IDLE, 1'b0);
		repeat (700) @(posedge pclk);
		chk(mod_reset_q, 1'b1);
		q.delete();
		pulse_sync();
		repeat (40) @(posedge pclk);
		chk(mod_reset_q, 1'b0);
		repeat (700) @(posedge pclk);
		chk(q.size(), 4);
		chk(mod_reset_q, 1'b1);
		apb(1'b1, IDX_MISC, 32'h0000_0001);
		for (int r = 0; r < 2; r++)
		begin
			mode(MODE_DUTY, r[0]);
			wstb(1'b1);
			wstb(1'b0);
			q.delete();
			act = 0;
			st = 0;
			do begin @(posedge pclk); act++; end while (standby_state_q !== 1'b1);
			do begin @(posedge pclk); st++; if (st == 4) chk(ref_hold_q, 1'b1); end while (standby_state_q === 1'b1);
			chk(q.size(), 2);
			// Edge cycles of the phase changes are allowed a few cycles of slack
			chk(st >= (r ? 15 : 3) * act - 4 && st <= (r ? 15 : 3) * act + 4, 1'b1);
		end
		foreach (pdm[k])
		begin
			mode(pdm[k], 1'b0);
			repeat (300) @(posedge pclk);
			chk(q.size(), 0);
			chk(mod_reset_q, 1'b1);
		end
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
